// [pll_status_and_loop_fields.sv]
`timescale 1ns/1ps
// Behaviour
// RULE1: each input-clock fault flag reads 1 while that input is bad and clears itself when good again.
// RULE2: each reference fault flag reads 1 while the reference is bad and clears itself when good again.
// RULE3: each lock flag reads the pll lock state and is also driven on that pll's lock pin.
// RULE4: each holdover flag reads 1 while the oscillator is frozen and 0 while tracking.
// RULE5: in synthesizer and high-bandwidth modes the loop field splits into filter, order, enable, pump and reduce.
// RULE6: in low-bandwidth mode bits 6:3 are converter gain, bits 2:1 lower pump, bit 0 reduce.
// RULE7: the upper loop filter selects one of four values and reads as 00 in low-bandwidth mode.
// RULE8: modulator order 0 means second order and 1 means third order.
// RULE9: modulator enable 0 gives integer feedback and 1 gives fractional feedback.
// RULE10: upper pump codes 00, 01, 10 select 173, 346, 692 uA, forced 00 in low-bandwidth mode; 11 is never written.
// RULE11: the reduce option cuts pump current by one third.
// RULE12: lower pump codes 00 to 11 select 800, 400, 200, 100 uA in low-bandwidth mode.
// RULE13: software programs pump, reduce and filter as one tabulated set for 200 kHz to 2 MHz.
// RULE14: software uses pump 10, reduce 0, filter 11 and an 80 MHz reference for 4 MHz bandwidth.
// RULE15: mode 00 is low-bandwidth, 01 synthesizer, 10 and 11 high-bandwidth.
// RULE16: the four status flags are read only and ignore writes.
module pll_status_and_loop_fields (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    // register port, one pll selected per access
    input  wire logic [1:0]  pll_sel_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic        reg_write_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic [7:0]       reg_rdata_o,
    // analog status, asynchronous
    input  wire logic [3:0]  input_clock_bad_i,
    input  wire logic [3:0]  ref_clock_bad_i,
    input  wire logic [3:0]  pll_locked_i,
    input  wire logic [3:0]  holdover_active_i,
    // lock pins
    output logic [3:0]       lock_pin_o,
    // decoded controls per pll, flattened
    output logic [7:0]       upper_loop_filter_sel_o,
    output logic [3:0]       modulator_order_sel_o,
    output logic [3:0]       modulator_enable_o,
    output logic [7:0]       upper_pump_current_sel_o,
    output logic [3:0]       pump_reduce_option_o,
    output logic [15:0]      converter_gain_sel_o,
    output logic [7:0]       lower_pump_current_sel_o,
    output logic [3:0]       low_bw_mode_o
);
    ////////////////////////////////////////////////////////////////
    // one two-stage synchroniser per status kind; the flags follow the
    // live status, so they self-clear with no write
    logic [3:0]  in_fault_meta_reg;
    logic [3:0]  in_fault_sync_reg;
    logic [3:0]  ref_fault_meta_reg;
    logic [3:0]  ref_fault_sync_reg;
    logic [3:0]  locked_meta_reg;
    logic [3:0]  locked_sync_reg;
    logic [3:0]  hold_meta_reg;
    logic [3:0]  hold_sync_reg;
    logic [3:0]  input_clock_fault;
    logic [3:0]  ref_clock_fault;
    logic [3:0]  pll_locked_flag;
    logic [3:0]  holdover_flag;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_fault_meta_reg <= 4'h0;
            in_fault_sync_reg <= 4'h0;
        end else begin
            in_fault_meta_reg <= input_clock_bad_i;
            in_fault_sync_reg <= in_fault_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_fault_meta_reg <= 4'h0;
            ref_fault_sync_reg <= 4'h0;
        end else begin
            ref_fault_meta_reg <= ref_clock_bad_i;
            ref_fault_sync_reg <= ref_fault_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            locked_meta_reg <= 4'h0;
            locked_sync_reg <= 4'h0;
        end else begin
            locked_meta_reg <= pll_locked_i;
            locked_sync_reg <= locked_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_meta_reg <= 4'h0;
            hold_sync_reg <= 4'h0;
        end else begin
            hold_meta_reg <= holdover_active_i;
            hold_sync_reg <= hold_meta_reg;
        end
    end

    assign input_clock_fault = in_fault_sync_reg; // RULE1
    assign ref_clock_fault   = ref_fault_sync_reg; // RULE2
    assign pll_locked_flag   = locked_sync_reg; // RULE3
    assign holdover_flag     = hold_sync_reg; // RULE4
    assign lock_pin_o        = pll_locked_flag; // RULE3

    ////////////////////////////////////////////////////////////////
    // settings storage, one copy per pll; status has no storage, so a
    // write to its address reaches nothing
    logic        loop_hi_reg [4];
    logic [5:0]  loop_lo_reg [4];
    logic [1:0]  pll_mode_select_reg [4];
    logic        write_hi;
    logic        write_lo;
    logic        write_mode;
    logic [7:0]  rdata_next;

    assign write_hi   = reg_write_i && (reg_addr_i == pll_status_pkg::LOOP_HI_ADDR);
    assign write_lo   = reg_write_i && (reg_addr_i == pll_status_pkg::LOOP_LO_ADDR);
    assign write_mode = reg_write_i && (reg_addr_i == pll_status_pkg::MODE_ADDR);
    // no write strobe exists for the status address  RULE16

    for (genvar g = 0; g < 4; g++) begin : g_pll
        logic        picked;
        logic [1:0]  filt_next;
        logic        order_next;
        logic        enable_next;
        logic [1:0]  pump_next;
        logic        reduce_next;
        logic [3:0]  gain_next;
        logic [1:0]  lpump_next;
        logic        low_next;

        assign picked = (pll_sel_i == 2'(g));

        // loop field bit 6 lives alone in the upper register
        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                loop_hi_reg[g] <= pll_status_pkg::LOOP_RESET[6];
            end else if (write_hi && picked) begin
                loop_hi_reg[g] <= reg_wdata_i[pll_status_pkg::LOOP_HI_BIT];
            end
        end

        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                loop_lo_reg[g] <= pll_status_pkg::LOOP_RESET[5:0];
            end else if (write_lo && picked) begin
                loop_lo_reg[g] <= reg_wdata_i[pll_status_pkg::LOOP_LO_LSB +: 6];
            end
        end

        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                pll_mode_select_reg[g] <= pll_status_pkg::MODE_RESET;
            end else if (write_mode && picked) begin
                pll_mode_select_reg[g] <= reg_wdata_i[pll_status_pkg::MODE_LSB +: 2];
            end
        end

        loop_field_decode u_decode (
            .loop_setting_field_i     ({loop_hi_reg[g], loop_lo_reg[g]}),
            .pll_mode_select_i        (pll_mode_select_reg[g]),
            .upper_loop_filter_sel_o  (filt_next),
            .modulator_order_sel_o    (order_next),
            .modulator_enable_o       (enable_next),
            .upper_pump_current_sel_o (pump_next),
            .pump_reduce_option_o     (reduce_next),
            .converter_gain_sel_o     (gain_next),
            .lower_pump_current_sel_o (lpump_next),
            .low_bw_mode_o            (low_next)
        );

        // controls leave through flip-flops so the analog side never sees
        // decode glitches; they follow a write one edge after it is taken
        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                upper_loop_filter_sel_o[2*g +: 2]  <= pll_status_pkg::CODE_ZERO;
                modulator_order_sel_o[g]           <= 1'b0;
                modulator_enable_o[g]              <= 1'b0;
                upper_pump_current_sel_o[2*g +: 2] <= pll_status_pkg::CODE_ZERO;
                pump_reduce_option_o[g]            <= 1'b0;
                converter_gain_sel_o[4*g +: 4]     <= 4'h0;
                lower_pump_current_sel_o[2*g +: 2] <= pll_status_pkg::CODE_ZERO;
                // mode resets to low bandwidth, so the flag starts where decode starts
                low_bw_mode_o[g] <= (pll_status_pkg::MODE_RESET == pll_status_pkg::MODE_LOW_BW);
            end else begin
                upper_loop_filter_sel_o[2*g +: 2]  <= filt_next; // RULE7
                modulator_order_sel_o[g]           <= order_next; // RULE8
                modulator_enable_o[g]              <= enable_next; // RULE9
                upper_pump_current_sel_o[2*g +: 2] <= pump_next; // RULE10
                pump_reduce_option_o[g]            <= reduce_next; // RULE11
                converter_gain_sel_o[4*g +: 4]     <= gain_next; // RULE6
                lower_pump_current_sel_o[2*g +: 2] <= lpump_next; // RULE12
                low_bw_mode_o[g]                   <= low_next; // RULE15
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // read data is registered, so it answers for the previous cycle's address
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr_i)
            pll_status_pkg::LOOP_HI_ADDR: begin
                rdata_next[pll_status_pkg::LOOP_HI_BIT] = loop_hi_reg[pll_sel_i];
            end
            pll_status_pkg::LOOP_LO_ADDR: begin
                rdata_next[pll_status_pkg::LOOP_LO_LSB +: 6] = loop_lo_reg[pll_sel_i];
            end
            pll_status_pkg::MODE_ADDR: begin
                rdata_next[pll_status_pkg::MODE_LSB +: 2] = pll_mode_select_reg[pll_sel_i];
            end
            pll_status_pkg::STATUS_ADDR: begin
                rdata_next[pll_status_pkg::ST_HOLD_BIT]     = holdover_flag[pll_sel_i]; // RULE4
                rdata_next[pll_status_pkg::ST_INFAULT_BIT]  = input_clock_fault[pll_sel_i]; // RULE1
                rdata_next[pll_status_pkg::ST_REFFAULT_BIT] = ref_clock_fault[pll_sel_i]; // RULE2
                rdata_next[pll_status_pkg::ST_LOCK_BIT]     = pll_locked_flag[pll_sel_i]; // RULE3
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end
endmodule

// [pll_status_pkg.sv]
package pll_status_pkg;
    localparam int unsigned NUM_PLL        = 4;
    localparam int unsigned LOOP_W         = 7;
    localparam int unsigned ADDR_W         = 5;
    localparam int unsigned REG_W          = 8;
    // register addresses within one pll's page
    localparam logic [4:0] LOOP_HI_ADDR    = 5'h10;
    localparam logic [4:0] LOOP_LO_ADDR    = 5'h12;
    localparam logic [4:0] MODE_ADDR       = 5'h14;
    localparam logic [4:0] STATUS_ADDR     = 5'h17;
    // field positions
    localparam int unsigned LOOP_HI_BIT    = 0;
    localparam int unsigned LOOP_LO_LSB    = 2;
    localparam int unsigned MODE_LSB       = 6;
    localparam int unsigned ST_HOLD_BIT    = 6;
    localparam int unsigned ST_INFAULT_BIT = 4;
    localparam int unsigned ST_REFFAULT_BIT = 3;
    localparam int unsigned ST_LOCK_BIT    = 2;
    // reset values and codes
    localparam logic [6:0] LOOP_RESET      = 7'h00;
    localparam logic [1:0] MODE_RESET      = 2'h0;
    localparam logic [1:0] CODE_ZERO       = 2'h0;
    localparam logic [1:0] CODE_RESERVED   = 2'h3;
    localparam logic [1:0] MODE_LOW_BW     = 2'h0;
    localparam logic [1:0] MODE_SYNTH      = 2'h1;
    typedef enum logic [1:0] {LOW_BW, SYNTH, HIGH_BW} pll_mode_t;
endpackage

// [loop_field_decode.sv]
`timescale 1ns/1ps
module loop_field_decode (
    // settings
    input  wire logic [6:0] loop_setting_field_i,
    input  wire logic [1:0] pll_mode_select_i,
    // decoded controls
    output logic [1:0]      upper_loop_filter_sel_o,
    output logic            modulator_order_sel_o,
    output logic            modulator_enable_o,
    output logic [1:0]      upper_pump_current_sel_o,
    output logic            pump_reduce_option_o,
    output logic [3:0]      converter_gain_sel_o,
    output logic [1:0]      lower_pump_current_sel_o,
    output logic            low_bw_mode_o
);
    pll_status_pkg::pll_mode_t mode;

    always_comb begin
        unique case (pll_mode_select_i)
            pll_status_pkg::MODE_LOW_BW: mode = pll_status_pkg::LOW_BW; // RULE15
            pll_status_pkg::MODE_SYNTH:  mode = pll_status_pkg::SYNTH; // RULE15
            default:                     mode = pll_status_pkg::HIGH_BW; // RULE15
        endcase
    end

    always_comb begin
        low_bw_mode_o            = (mode == pll_status_pkg::LOW_BW);
        pump_reduce_option_o     = loop_setting_field_i[0]; // RULE11
        upper_loop_filter_sel_o  = pll_status_pkg::CODE_ZERO;
        modulator_order_sel_o    = 1'b0;
        modulator_enable_o       = 1'b0;
        upper_pump_current_sel_o = pll_status_pkg::CODE_ZERO;
        converter_gain_sel_o     = 4'h0;
        lower_pump_current_sel_o = pll_status_pkg::CODE_ZERO;
        if (low_bw_mode_o) begin
            converter_gain_sel_o     = loop_setting_field_i[6:3]; // RULE6
            lower_pump_current_sel_o = loop_setting_field_i[2:1]; // RULE6 RULE12
        end else begin
            upper_loop_filter_sel_o = loop_setting_field_i[6:5]; // RULE5 RULE7
            modulator_order_sel_o   = loop_setting_field_i[4]; // RULE5 RULE8
            modulator_enable_o      = loop_setting_field_i[3]; // RULE5 RULE9
            // reserved code falls back to the lowest current
            if (loop_setting_field_i[2:1] != pll_status_pkg::CODE_RESERVED) begin
                upper_pump_current_sel_o = loop_setting_field_i[2:1]; // RULE10
            end
        end
    end
endmodule

// [pll_status_and_loop_fields_checker.sv]
`timescale 1ns/1ps
module pll_status_and_loop_fields_checker (
    input wire logic        sys_clk_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  pll_sel_i,
    input wire logic [4:0]  reg_addr_i,
    input wire logic        reg_write_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [3:0]  pll_locked_i,
    input wire logic [3:0]  lock_pin_o,
    input wire logic [7:0]  upper_loop_filter_sel_o,
    input wire logic [3:0]  modulator_order_sel_o,
    input wire logic [7:0]  upper_pump_current_sel_o,
    input wire logic [15:0] converter_gain_sel_o,
    input wire logic [3:0]  low_bw_mode_o
);
    logic [1:0] up_reg;
    logic       sel_lock;
    assign sel_lock = lock_pin_o[pll_sel_i];
    // counts edges since reset so the sync stages are filled
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_lock_pin; up_reg == 2'h3 |-> lock_pin_o == $past(pll_locked_i, 2); endproperty
    a_lock_pin: assert property (p_lock_pin) else $error("lock pin lags");
    property p_lock_read; $past(reg_addr_i) == 5'h17 |-> reg_rdata_o[2] == $past(sel_lock); endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock flag read");
    property p_filt_low; low_bw_mode_o[0] |-> upper_loop_filter_sel_o[1:0] == 2'h0; endproperty
    a_filt_low: assert property (p_filt_low) else $error("filter not zero");
    property p_pump_low; low_bw_mode_o[1] |-> upper_pump_current_sel_o[3:2] == 2'h0; endproperty
    a_pump_low: assert property (p_pump_low) else $error("pump not zero");
    property p_order_low; low_bw_mode_o[2] |-> !modulator_order_sel_o[2]; endproperty
    a_order_low: assert property (p_order_low) else $error("order not zero");
    property p_gain_high; !low_bw_mode_o[3] |-> converter_gain_sel_o[15:12] == 4'h0; endproperty
    a_gain_high: assert property (p_gain_high) else $error("gain not zero");
    property p_pump_rsv; upper_pump_current_sel_o[1:0] != 2'h3; endproperty
    a_pump_rsv: assert property (p_pump_rsv) else $error("reserved pump");
    property p_mode_hold; up_reg != 2'h0 && !$past(reg_write_i, 2) |-> $stable(low_bw_mode_o); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
endmodule
bind pll_status_and_loop_fields pll_status_and_loop_fields_checker chk (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .pll_sel_i(pll_sel_i), .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
    .reg_rdata_o(reg_rdata_o), .pll_locked_i(pll_locked_i), .lock_pin_o(lock_pin_o),
    .upper_loop_filter_sel_o(upper_loop_filter_sel_o), .modulator_order_sel_o(modulator_order_sel_o),
    .upper_pump_current_sel_o(upper_pump_current_sel_o), .converter_gain_sel_o(converter_gain_sel_o),
    .low_bw_mode_o(low_bw_mode_o));

// [pll_host_model.sv]
`timescale 1ns/1ps
module pll_host_model (
    input  wire logic  sys_clk_i,
    output logic [1:0] pll_sel_o,
    output logic [4:0] reg_addr_o,
    output logic       reg_write_o,
    output logic [7:0] reg_wdata_o,
    output logic       rd_pend_o
);
    initial begin
        {pll_sel_o, reg_addr_o, reg_write_o, reg_wdata_o, rd_pend_o} = '0;
    end
    // kind 0 idle, 1 write, 2 read; idle data is scrambled
    task automatic op(input logic [1:0] sel, input logic [4:0] addr, input logic [7:0] data, input int kind);
        @(negedge sys_clk_i);
        pll_sel_o = sel;
        reg_addr_o = addr;
        // the upper pump code sits in bits 4:3 of the low loop register; never send its reserved code
        reg_wdata_o = (kind != 1) ? ~reg_wdata_o
            : (addr == pll_status_pkg::LOOP_LO_ADDR && data[4:3] == 2'h3) ? (data & 8'hf7) : data;
        reg_write_o = (kind == 1);
        rd_pend_o = (kind == 2);
    endtask
endmodule

// [test_pll_status_and_loop_fields.sv]
`timescale 1ns/1ps
module test_pll_status_and_loop_fields;
    logic        sys_clk_i = 1'h0, reset_n_i = 1'h0, we, rd_pend, rd_done = 1'h0, dec_chk = 1'h0;
    logic [3:0]  in_bad = 4'h0, ref_bad = 4'h0, locked = 4'h0, hold = 4'h0;
    logic [3:0]  lock_pin, order, en, reduce, low, t;
    logic [7:0]  rdata, filt, pump, lpump, wdata, q_rd[$];
    logic [15:0] gain, e, q_dec[$];
    logic [1:0]  sel, cur_p, m;
    logic [4:0]  addr, tb;
    logic [6:0]  f;
    logic [31:0] rnd = 32'h0000_1832;
    int          err_count = 0, checks_done = 0;
    localparam logic [4:0] BW_TAB [5] = '{5'h01, 5'h0b, 5'h15, 5'h1d, 5'h1c};
    always #2 sys_clk_i = ~sys_clk_i;
    pll_host_model host (.sys_clk_i(sys_clk_i), .pll_sel_o(sel), .reg_addr_o(addr), .reg_write_o(we),
        .reg_wdata_o(wdata), .rd_pend_o(rd_pend));
    pll_status_and_loop_fields dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pll_sel_i(sel),
        .reg_addr_i(addr), .reg_write_i(we), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .input_clock_bad_i(in_bad), .ref_clock_bad_i(ref_bad), .pll_locked_i(locked),
        .holdover_active_i(hold), .lock_pin_o(lock_pin), .upper_loop_filter_sel_o(filt),
        .modulator_order_sel_o(order), .modulator_enable_o(en), .upper_pump_current_sel_o(pump),
        .pump_reduce_option_o(reduce), .converter_gain_sel_o(gain), .lower_pump_current_sel_o(lpump),
        .low_bw_mode_o(low));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic compare(input string what, input logic [13:0] exp, input logic [13:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk_i) rd_done <= rd_pend;
    always @(negedge sys_clk_i) begin
        if (rd_done) compare("read data", {6'h00, q_rd.pop_front()}, {6'h00, rdata});
        if (dec_chk) begin
            e = q_dec.pop_front();
            compare("decode", e[13:0], {filt[2*e[15:14]+:2], order[e[15:14]], en[e[15:14]],
                pump[2*e[15:14]+:2], reduce[e[15:14]], gain[4*e[15:14]+:4], lpump[2*e[15:14]+:2], low[e[15:14]]});
        end
    end
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        err_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i) reset_n_i = 1'h1;
        for (int i = 0; i < 12; i++) begin
            rnd = xs(rnd);
            {in_bad, ref_bad, locked, hold} = (i % 3 == 2) ? 16'h0000 : rnd[15:0];
            repeat (3) host.op(2'h0, 5'h00, 8'h00, 0);
            compare("lock pin", {10'h000, locked}, {10'h000, lock_pin});
            for (int p = 0; p < 4; p++) begin
                if (p == 1) host.op(2'(p), pll_status_pkg::STATUS_ADDR, 8'hff, 1);
                host.op(2'(p), pll_status_pkg::STATUS_ADDR, 8'h00, 2);
                q_rd.push_back({1'h0, hold[p], 1'h0, in_bad[p], ref_bad[p], locked[p], 2'h0});
            end
            host.op(2'h0, 5'h01, 8'h00, 2);
            q_rd.push_back(8'h00);
        end
        for (int k = 0; k < 20; k++) begin
            rnd = xs(rnd);
            cur_p = rnd[9:8];
            m = 2'(k % 4);
            tb = BW_TAB[k % 5];
            f = {tb[4:3], rnd[1:0], tb[2:0]};
            host.op(cur_p, pll_status_pkg::MODE_ADDR, {m, 6'h00}, 1);
            host.op(cur_p, pll_status_pkg::LOOP_HI_ADDR, {7'h00, f[6]}, 1);
            host.op(cur_p, pll_status_pkg::LOOP_LO_ADDR, {f[5:0], 2'h0}, 1);
            host.op(cur_p, pll_status_pkg::MODE_ADDR, 8'h00, 2);
            q_rd.push_back({m, 6'h00});
            q_dec.push_back({cur_p, (m == 2'h0) ? {6'h00, f[0], f[6:3], f[2:1], 1'h1}
                : {f[6:5], f[4], f[3], f[2:1], f[0], 7'h00}});
            dec_chk <= 1'h1;
            host.op(cur_p, pll_status_pkg::LOOP_HI_ADDR, 8'h00, 2);
            q_rd.push_back({7'h00, f[6]});
            dec_chk <= 1'h0;
            host.op(cur_p, pll_status_pkg::LOOP_LO_ADDR, 8'h00, 2);
            q_rd.push_back({f[5:0], 2'h0});
        end
        repeat (2) host.op(2'h0, 5'h00, 8'h00, 0);
        summarize();
    end
endmodule
